//--- src/aou_ctrl_regs.svh
// register offsets, field positions, reset values and timing counts
// assumes a 20 MHz clock and a 32-bit apb slave with byte addresses
`ifndef AOU_CTRL_REGS_SVH
`define AOU_CTRL_REGS_SVH
`define AOU_OFF_SET1        12'h000
`define AOU_OFF_SET2        12'h004
`define AOU_OFF_CTRL        12'h008
`define AOU_OFF_STAT        12'h00c
`define AOU_OFF_CFG0        12'h010
`define AOU_OFF_BASE        12'h024
`define AOU_CFG_WORDS       5
`define AOU_CFG_OUT_LO      0
`define AOU_CFG_OUT_HI      1
`define AOU_CFG_ALM_LO      2
`define AOU_CFG_ALM_HI      3
`define AOU_CFG_DBAND       4
`define AOU_CTRL_PSEL_LSB   0
`define AOU_CTRL_A1EN_BIT   4
`define AOU_CTRL_A2EN_BIT   5
`define AOU_CTRL_L1EN_BIT   6
`define AOU_CTRL_L2EN_BIT   7
`define AOU_CTRL_INH_BIT    8
`define AOU_DIP_RANGE_BIT   0
`define AOU_DIP_CHAN_BIT    1
`define AOU_DIP_PEN_BIT     2
`define AOU_SET_MAX         12'hfff
`define AOU_CFG_RST_HI      12'hfff
`define AOU_UNIT_MAX        4'h9
`define AOU_RFSH_BASE       100
`define AOU_RFSH_STEP       10
`define AOU_CFGM_BASE       1000
`define AOU_CFGM_STEP       100
`define AOU_CLK_HZ          20000000
`define AOU_PULSE_UNIT_MS   1000
`define AOU_PULSE_STEPS     4096
`define AOU_TICK_CYCLES \
  ((`AOU_CLK_HZ / 1000) * `AOU_PULSE_UNIT_MS / `AOU_PULSE_STEPS)
`endif

//--- src/aou_ctrl_pkg.sv
// types of the analog output unit control block
// assumes aou_ctrl_regs.svh is on the include path
`default_nettype none
package aou_ctrl_pkg;
`include "aou_ctrl_regs.svh"
  typedef enum logic [2:0]
  {
    ST_INIT = 3'b001,
    ST_RUN  = 3'b010,
    ST_HALT = 3'b100
  } aou_state_e;

  typedef logic [11:0] aou_val_t;

  typedef struct packed
  {
    aou_state_e                              state;
    aou_val_t                                set1;
    aou_val_t                                set2;
    logic [8:0]                              ctrl;
    logic [`AOU_CFG_WORDS-1:0][11:0]         cfg_stage;
    logic [`AOU_CFG_WORDS-1:0][11:0]         cfg_live;
    logic [3:0]                              dip;
    logic [3:0]                              unit;
    logic                                    restart_d;
    logic [3:0]                              alarm;
    logic [15:0]                             tick_cnt;
    logic [4:0]                              step_cnt;
    aou_val_t                                phase;
    aou_val_t                                out1;
    aou_val_t                                out2;
    logic [1:0]                              pulse;
    logic [31:0]                             prdata;
  } aou_state_s;
endpackage : aou_ctrl_pkg
`default_nettype wire

//--- src/aou_ctrl.sv
// control logic of a two-channel analog output unit
// assumes synchronous switch and flag inputs, apb master on the cpu side
//
// Operation
// [RQ1] run light on when healthy, else halt
// [RQ2] alarm light follows any limit alarm
// [RQ3] one range for both channels
// [RQ4] clamp output to configured limits when enabled
// [RQ5] alarm outside window, output left unchanged
// [RQ6] alarm clears only past deadband
// [RQ7] pulse output on its own terminal
// [RQ8] bases from unit number: 100/10, 1000/100
// [RQ9] unit number zero after reset
// [RQ10] duplicate unit fault stops operation
// [RQ11] unit change acts only after restart
// [RQ12] switch 1 selects output range
// [RQ13] switch 2 selects pulse channel
// [RQ14] switch 3 enables pulse output
// [RQ15] pulse on at most one channel
// [RQ16] installer sets switches before power-up
// [RQ17] setting words, pulse duty from value
// [RQ18] inhibit bit suppresses outputs
// [RQ19] unsigned twelve-bit comparisons
// [RQ20] switches and limits latched at restart
//
// Added by the designer: the APB register port and the placing of the registers.
`default_nettype none
`include "aou_ctrl_regs.svh"
module aou_ctrl
  import aou_ctrl_pkg::*;
#(
  parameter int TICK_CYCLES = `AOU_TICK_CYCLES
)
(
  input  wire logic        clock,
  input  wire logic        nrst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic             pslverr,
  output logic [31:0]      prdata,
  input  wire logic [3:0]  unit_switch,
  input  wire logic [3:0]  dip_switch,
  input  wire logic        restart_flag,
  input  wire logic        dup_unit_fault,
  output logic             unit_fault,
  output logic             run_led,
  output logic             alarm_led,
  output logic             range_0_10v,
  output logic             out_enable,
  output logic [11:0]      out1_code,
  output logic [11:0]      out2_code,
  output logic             pulse1,
  output logic             pulse2,
  output logic [1:0]       alarm_upper,
  output logic [1:0]       alarm_lower,
  output logic [7:0]       refresh_base,
  output logic [10:0]      config_base
);

  if (TICK_CYCLES < 1 || TICK_CYCLES > 65535)
  begin : tick_range_chk
    $error("TICK_CYCLES out of range");
  end

  ////////////////////////////////////////////////////////////////////////
  // unsigned helpers shared by both channels

  function automatic aou_val_t clamp_val(aou_val_t v, aou_val_t lo,
                                         aou_val_t hi, logic en);
    aou_val_t r;
    r = v;
    if (en && v > hi)
      r = hi;
    else if (en && v < lo)
      r = lo;
    return r;
  endfunction : clamp_val

  // returns {upper, lower}; set beats clear so an edge is never lost
  function automatic logic [1:0] alarm_val(logic [1:0] cur, aou_val_t v,
                                           aou_val_t lo, aou_val_t hi,
                                           aou_val_t db, logic en);
    logic [12:0] hi_clr;
    logic [12:0] lo_clr;
    logic [1:0]  r;
    hi_clr = {1'b0, hi} - {1'b0, db};
    lo_clr = {1'b0, lo} + {1'b0, db};
    r = cur;
    if (!en)
      r = 2'b00;
    else
    begin
      if (v > hi)
        r[1] = 1'b1;
      else if ({1'b0, v} <= hi_clr || hi_clr[12])
        r[1] = 1'b0;
      if (v < lo)
        r[0] = 1'b1;
      else if ({1'b0, v} >= lo_clr)
        r[0] = 1'b0;
    end
    return r;
  endfunction : alarm_val

  ////////////////////////////////////////////////////////////////////////
  // state

  aou_state_s r_reg;
  aou_state_s r_next;

  logic       restart_evt;
  logic       setting_err;
  logic       healthy;
  logic       inhibit;
  logic [4:0] period_mult;
  logic       step_tick;
  logic [2:0] psel_code;

  assign restart_evt = restart_flag && !r_reg.restart_d;
  // [RQ19] unsigned limit order check
  assign setting_err = (r_reg.cfg_live[`AOU_CFG_OUT_LO] >
                        r_reg.cfg_live[`AOU_CFG_OUT_HI]) ||
                       (r_reg.cfg_live[`AOU_CFG_ALM_LO] >
                        r_reg.cfg_live[`AOU_CFG_ALM_HI]);
  assign inhibit     = r_reg.ctrl[`AOU_CTRL_INH_BIT];
  assign psel_code   = r_reg.ctrl[`AOU_CTRL_PSEL_LSB +: 3];
  assign healthy     = (r_reg.state == ST_RUN);
  assign step_tick   = (r_reg.tick_cnt == 16'(TICK_CYCLES - 1));

  always_comb
  begin
    case (psel_code)
      3'h0:    period_mult = 5'h01;
      3'h1:    period_mult = 5'h02;
      3'h2:    period_mult = 5'h05;
      3'h3:    period_mult = 5'h0a;
      3'h4:    period_mult = 5'h14;
      default: period_mult = 5'h01;
    endcase
  end

  always_comb
  begin
    r_next = r_reg;
    r_next.restart_d = restart_flag;
    r_next.prdata = 32'h0000_0000;

    // register writes land on the access cycle
    if (psel && penable && pwrite)
    begin
      case (paddr)
        // [RQ17] setting words
        `AOU_OFF_SET1: r_next.set1 = pwdata[11:0];
        `AOU_OFF_SET2: r_next.set2 = pwdata[11:0];
        `AOU_OFF_CTRL: r_next.ctrl = pwdata[8:0];
        default:
        begin
          for (int i = 0; i < `AOU_CFG_WORDS; i++)
            if (paddr == 12'(`AOU_OFF_CFG0 + 4 * i))
              r_next.cfg_stage[i] = pwdata[11:0];
        end
      endcase
    end

    // read data is captured in the setup cycle so it comes from a flop
    if (psel && !penable && !pwrite)
    begin
      case (paddr)
        `AOU_OFF_SET1: r_next.prdata = {20'h00000, r_reg.set1};
        `AOU_OFF_SET2: r_next.prdata = {20'h00000, r_reg.set2};
        `AOU_OFF_CTRL: r_next.prdata = {23'h000000, r_reg.ctrl};
        `AOU_OFF_STAT:
          r_next.prdata = {23'h000000, r_reg.state, healthy, r_reg.alarm,
                           setting_err};
        `AOU_OFF_BASE:
          r_next.prdata = {5'h00, config_base, 8'h00, refresh_base};
        default:
        begin
          for (int i = 0; i < `AOU_CFG_WORDS; i++)
            if (paddr == 12'(`AOU_OFF_CFG0 + 4 * i))
              r_next.prdata = {20'h00000, r_reg.cfg_stage[i]};
        end
      endcase
    end

    case (r_reg.state)
      ST_INIT:
      begin
        // [RQ20] switches and limits taken once per start
        // [RQ16] switches are trusted as set before start-up
        // [RQ11] new unit number only taken here
        r_next.dip      = dip_switch;
        r_next.unit     = unit_switch;
        r_next.cfg_live = r_reg.cfg_stage;
        r_next.alarm    = 4'h0;
        r_next.state    = ST_RUN;
      end
      ST_RUN:
      begin
        // [RQ1] abnormal operation stops the unit
        // [RQ10] duplicate unit number halts as well
        if (dup_unit_fault || setting_err || r_reg.unit > `AOU_UNIT_MAX)
          r_next.state = ST_HALT;
      end
      ST_HALT:
        r_next.state = ST_HALT;
      default:
        r_next.state = ST_HALT;
    endcase
    if (restart_evt)
      r_next.state = ST_INIT;

    // [RQ4] clamp to the live limits
    r_next.out1 = clamp_val(r_reg.set1, r_reg.cfg_live[`AOU_CFG_OUT_LO],
                            r_reg.cfg_live[`AOU_CFG_OUT_HI],
                            r_reg.ctrl[`AOU_CTRL_L1EN_BIT]);
    r_next.out2 = clamp_val(r_reg.set2, r_reg.cfg_live[`AOU_CFG_OUT_LO],
                            r_reg.cfg_live[`AOU_CFG_OUT_HI],
                            r_reg.ctrl[`AOU_CTRL_L2EN_BIT]);

    // [RQ5] alarms only observe the output value
    // [RQ6] deadband delays the clear
    if (healthy)
    begin
      r_next.alarm[1:0] = alarm_val(r_reg.alarm[1:0], r_reg.out1,
        r_reg.cfg_live[`AOU_CFG_ALM_LO], r_reg.cfg_live[`AOU_CFG_ALM_HI],
        r_reg.cfg_live[`AOU_CFG_DBAND], r_reg.ctrl[`AOU_CTRL_A1EN_BIT]);
      r_next.alarm[3:2] = alarm_val(r_reg.alarm[3:2], r_reg.out2,
        r_reg.cfg_live[`AOU_CFG_ALM_LO], r_reg.cfg_live[`AOU_CFG_ALM_HI],
        r_reg.cfg_live[`AOU_CFG_DBAND], r_reg.ctrl[`AOU_CTRL_A2EN_BIT]);
    end

    // pulse timebase: one phase step per tick*mult, 4096 steps a period
    r_next.tick_cnt = step_tick ? 16'h0000 : r_reg.tick_cnt + 16'h0001;
    if (step_tick)
    begin
      if (r_reg.step_cnt >= period_mult - 5'h01)
      begin
        r_next.step_cnt = 5'h00;
        r_next.phase    = r_reg.phase + 12'h001;
      end
      else
        r_next.step_cnt = r_reg.step_cnt + 5'h01;
    end

    // [RQ7] pulse drives its own terminal pair
    // [RQ13] switch 2 picks the channel
    // [RQ14] switch 3 gates the pulse
    // [RQ15] only one of the two bits can ever be set
    r_next.pulse = 2'b00;
    if (healthy && !inhibit && r_reg.dip[`AOU_DIP_PEN_BIT])
    begin
      if (r_reg.dip[`AOU_DIP_CHAN_BIT])
        r_next.pulse[1] = r_reg.phase < r_reg.set2;
      else
        r_next.pulse[0] = r_reg.phase < r_reg.set1;
    end
  end

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      r_reg       <= '0;
      // [RQ9] unit zero until the first sample
      r_reg.unit  <= 4'h0;
      r_reg.state <= ST_INIT;
      for (int i = 0; i < `AOU_CFG_WORDS; i++)
      begin
        r_reg.cfg_stage[i] <= 12'h000;
        r_reg.cfg_live[i]  <= 12'h000;
      end
      r_reg.cfg_stage[`AOU_CFG_OUT_HI] <= `AOU_CFG_RST_HI;
      r_reg.cfg_stage[`AOU_CFG_ALM_HI] <= `AOU_CFG_RST_HI;
      r_reg.cfg_live[`AOU_CFG_OUT_HI]  <= `AOU_CFG_RST_HI;
      r_reg.cfg_live[`AOU_CFG_ALM_HI]  <= `AOU_CFG_RST_HI;
    end
    else
      r_reg <= r_next;
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs

  assign pready  = 1'b1;
  assign pslverr = 1'b0;
  assign prdata  = r_reg.prdata;
  assign unit_fault  = dup_unit_fault;
  assign run_led     = healthy;
  // [RQ2] alarm light from the alarm flags
  assign alarm_led   = |r_reg.alarm;
  // [RQ3] one range pin serves both channels
  // [RQ12] switch 1 picks the range
  assign range_0_10v = r_reg.dip[`AOU_DIP_RANGE_BIT];
  // [RQ18] inhibit and halt both drop the outputs
  assign out_enable  = healthy && !inhibit;
  // the pulse channel still carries its analog code; the range pin decides
  assign out1_code   = out_enable ? r_reg.out1 : 12'h000;
  assign out2_code   = out_enable ? r_reg.out2 : 12'h000;
  assign pulse1      = r_reg.pulse[0];
  assign pulse2      = r_reg.pulse[1];
  assign alarm_upper = {r_reg.alarm[3], r_reg.alarm[1]};
  assign alarm_lower = {r_reg.alarm[2], r_reg.alarm[0]};
  // [RQ8] word bases from the latched unit number
  assign refresh_base = 8'(`AOU_RFSH_BASE + `AOU_RFSH_STEP * r_reg.unit);
  assign config_base  = 11'(`AOU_CFGM_BASE + `AOU_CFGM_STEP * r_reg.unit);

  ////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);

  dup_halts_a: assert property ( // [RQ10]
    dup_unit_fault && healthy && !restart_evt |=> !run_led ##1 !run_led)
    else $error("duplicate fault did not halt the unit");

  alarm_led_a: assert property ( // [RQ2]
    healthy && r_reg.ctrl[`AOU_CTRL_A1EN_BIT] &&
    r_reg.out1 > r_reg.cfg_live[`AOU_CFG_ALM_HI] |=> alarm_led)
    else $error("alarm light dark above upper limit");

  range_latch_a: assert property ( // [RQ12]
    r_reg.state == ST_INIT && !restart_evt |=>
      range_0_10v == $past(dip_switch[0]))
    else $error("range not taken from switch 1");

  held_cfg_a: assert property ( // [RQ20]
    r_reg.state != ST_INIT |=> $stable(r_reg.dip) && $stable(r_reg.unit))
    else $error("switches changed outside start");

  clamp_hi_a: assert property ( // [RQ4]
    healthy && !inhibit && r_reg.ctrl[`AOU_CTRL_L1EN_BIT] &&
    $stable(r_reg.set1) && r_reg.set1 > r_reg.cfg_live[`AOU_CFG_OUT_HI]
      ##1 healthy && !inhibit |->
      out1_code == r_reg.cfg_live[`AOU_CFG_OUT_HI])
    else $error("output not held at upper limit");

  pulse_one_a: assert property ( // [RQ15]
    pulse1 |-> !pulse2 && !r_reg.dip[`AOU_DIP_CHAN_BIT])
    else $error("pulse on both channels");

  pulse_off_a: assert property ( // [RQ14]
    !r_reg.dip[`AOU_DIP_PEN_BIT] |=> !pulse1 && !pulse2)
    else $error("pulse while disabled");

  inhibit_out_a: assert property ( // [RQ18]
    inhibit |-> (!out_enable && out1_code == 12'h000 &&
                 out2_code == 12'h000) ##1 (!pulse1 && !pulse2))
    else $error("outputs not suppressed by inhibit");

  base_map_a: assert property ( // [RQ8]
    r_reg.unit <= `AOU_UNIT_MAX |->
      config_base - 11'd1000 == 11'(10) * (11'(refresh_base) - 11'd100))
    else $error("word bases disagree with unit number");

  deadband_a: assert property ( // [RQ6]
    healthy && r_reg.alarm[1] && r_reg.ctrl[`AOU_CTRL_A1EN_BIT] &&
    {1'b0, r_reg.out1} > {1'b0, r_reg.cfg_live[`AOU_CFG_ALM_HI]} -
                         {1'b0, r_reg.cfg_live[`AOU_CFG_DBAND]} &&
    !restart_evt |=> r_reg.alarm[1])
    else $error("upper alarm cleared inside deadband");

endmodule : aou_ctrl
`default_nettype wire

//--- tb/aou_cpu_model.sv
// far-side model: controller cpu as apb master, plus switches and flags
// assumes the slave may stall; the answer is taken when pready is high
`default_nettype none
module aou_cpu_model
(
  input  wire logic        clock,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [11:0]      paddr,
  output logic [31:0]      pwdata,
  input  wire logic        pready,
  input  wire logic [31:0] prdata,
  output logic [3:0]       unit_switch,
  output logic [3:0]       dip_switch,
  output logic             restart_flag,
  output logic             dup_unit_fault
);
  timeunit 1ns;
  timeprecision 1ns;

  initial
  begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    unit_switch = 4'h0;
    dip_switch = 4'h0;
    restart_flag = 1'b0;
    dup_unit_fault = 1'b0;
  end

  // read data is taken at the edge where pready is sampled high
  task automatic xfer(input logic wr, input logic [11:0] a,
                      input logic [31:0] d, output logic [31:0] q);
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do
      @(posedge clock);
    while (pready !== 1'b1);
    q = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    // stale bus values are not left for the slave to lean on
    paddr <= ~a;
    pwdata <= ~d;
  endtask : xfer

  task automatic set_sw(input logic [3:0] u, input logic [3:0] d);
    @(posedge clock);
    unit_switch <= u;
    dip_switch <= {1'b0, d[2:0]};
  endtask : set_sw

  task automatic restart();
    @(posedge clock);
    restart_flag <= 1'b1;
    repeat (2) @(posedge clock);
    restart_flag <= 1'b0;
  endtask : restart

  task automatic dup(input logic v);
    @(posedge clock);
    dup_unit_fault <= v;
  endtask : dup
endmodule : aou_cpu_model
`default_nettype wire

//--- tb/tb.sv
// self-checking bench of the analog output unit control block
// assumes the cpu model drives apb and switches; pulse tick shortened
`default_nettype none
`define CHK(what, seen, exp) \
  begin \
    total_checks++; \
    if ((seen) !== (exp)) \
    begin \
      failures++; \
      $display("wrong value %s exp %h seen %h", what, exp, seen); \
    end \
  end
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  import aou_ctrl_pkg::*;

  localparam int TICK = 2;
  logic clock = 1'b0;
  logic nrst = 1'b0;
  logic psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr, out1_code, out2_code;
  logic [31:0] pwdata, prdata, q;
  logic [3:0] unit_switch, dip_switch;
  logic restart_flag, dup_unit_fault, unit_fault, run_led, alarm_led;
  logic range_0_10v, out_enable, pulse1, pulse2;
  logic [1:0] alarm_upper, alarm_lower;
  logic [7:0] refresh_base;
  logic [10:0] config_base;
  int failures = 0;
  int total_checks = 0;
  int c1, c2;

  always #25 clock = ~clock;

  aou_ctrl #(.TICK_CYCLES(TICK)) aou_ctrl_i (.clock(clock), .nrst(nrst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .prdata(prdata),
    .unit_switch(unit_switch), .dip_switch(dip_switch),
    .restart_flag(restart_flag), .dup_unit_fault(dup_unit_fault),
    .unit_fault(unit_fault), .run_led(run_led), .alarm_led(alarm_led),
    .range_0_10v(range_0_10v), .out_enable(out_enable),
    .out1_code(out1_code), .out2_code(out2_code), .pulse1(pulse1),
    .pulse2(pulse2), .alarm_upper(alarm_upper), .alarm_lower(alarm_lower),
    .refresh_base(refresh_base), .config_base(config_base));

  aou_cpu_model aou_cpu_model_i (.clock(clock), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .prdata(prdata), .unit_switch(unit_switch),
    .dip_switch(dip_switch), .restart_flag(restart_flag),
    .dup_unit_fault(dup_unit_fault));

  task automatic print_verdict();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : print_verdict

  // ends mid-cycle so outputs have settled
  task automatic wt(input int n);
    repeat (n) @(posedge clock);
    @(negedge clock);
  endtask : wt

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    aou_cpu_model_i.xfer(1'b1, a, d, q);
    wt(5);
  endtask : wr

  task automatic rd(input logic [11:0] a);
    aou_cpu_model_i.xfer(1'b0, a, 32'h0, q);
  endtask : rd

  task automatic pcount(input int n);
    c1 = 0;
    c2 = 0;
    repeat (n)
    begin
      @(negedge clock);
      c1 += int'(pulse1 === 1'b1);
      c2 += int'(pulse2 === 1'b1);
    end
  endtask : pcount

  initial
  begin
    repeat (80000) @(posedge clock);
    failures++;
    print_verdict();
  end

  initial
  begin
    repeat (16) @(posedge clock);
    nrst <= 1'b1;
    wt(4);
    `CHK("run", run_led, 1'b1)
    `CHK("rbase", refresh_base, 8'd100)
    `CHK("cbase", config_base, 11'd1000)
    `CHK("range", range_0_10v, 1'b0)
    rd(12'h00c);
    `CHK("stat run", q[5], 1'b1)
    `CHK("slverr", pslverr, 1'b0)
    rd(12'h100);
    `CHK("unmapped", q, 32'h0)
    wr(12'h000, 32'h234);
    wr(12'h004, 32'hfff);
    `CHK("out1", out1_code, 12'h234)
    `CHK("out2", out2_code, 12'hfff)
    rd(12'h000);
    `CHK("set1 rd", q, 32'h234)
    pcount(64);
    `CHK("no pulse", c1 + c2, 0)
    wr(12'h008, 32'h100);
    `CHK("inh en", out_enable, 1'b0)
    `CHK("inh out", out1_code, 12'h000)
    wr(12'h008, 32'h0);
    wr(12'h010, 32'h100);
    wr(12'h014, 32'h700);
    wr(12'h018, 32'h200);
    wr(12'h01c, 32'h600);
    wr(12'h020, 32'h040);
    aou_cpu_model_i.set_sw(4'h3, 4'h7);
    wt(4);
    `CHK("unit held", refresh_base, 8'd100)
    `CHK("dip held", range_0_10v, 1'b0)
    aou_cpu_model_i.restart();
    wt(4);
    `CHK("rbase3", refresh_base, 8'd130)
    `CHK("cbase3", config_base, 11'd1300)
    `CHK("range on", range_0_10v, 1'b1)
    rd(12'h024);
    `CHK("base rd", q, 32'h0514_0082)
    wr(12'h008, 32'h050);
    wr(12'h000, 32'hf00);
    `CHK("clamp", out1_code, 12'h700)
    `CHK("al up", alarm_upper, 2'b01)
    `CHK("al led", alarm_led, 1'b1)
    wr(12'h008, 32'h010);
    `CHK("no clamp", out1_code, 12'hf00)
    wr(12'h008, 32'h050);
    wr(12'h000, 32'h5f0);
    `CHK("db hold", alarm_upper, 2'b01)
    wr(12'h000, 32'h5c0);
    `CHK("db clr", alarm_upper, 2'b00)
    wr(12'h000, 32'h1f0);
    `CHK("al lo", alarm_lower, 2'b01)
    `CHK("lo led", alarm_led, 1'b1)
    wr(12'h000, 32'h240);
    `CHK("lo clr", alarm_lower, 2'b00)
    wr(12'h008, 32'h000);
    wr(12'h004, 32'h600);
    wt(20);
    pcount(4096 * TICK);
    `CHK("pulse ch1", c1, 0)
    `CHK("pulse duty", c2, 12'h600 * TICK)
    // period code 1 doubles the pulse period
    wr(12'h008, 32'h001);
    wt(20);
    pcount(4096 * TICK * 2);
    `CHK("pulse 2s", c2, 12'h600 * TICK * 2)
    aou_cpu_model_i.set_sw(4'h3, 4'h5);
    aou_cpu_model_i.restart();
    wt(20);
    pcount(4096 * TICK * 2);
    `CHK("pulse ch2 off", c2, 0)
    `CHK("pulse ch1 duty", c1, 12'h240 * TICK * 2)
    aou_cpu_model_i.dup(1'b1);
    wt(3);
    `CHK("ufault", unit_fault, 1'b1)
    `CHK("halt", run_led, 1'b0)
    `CHK("halt out", out_enable, 1'b0)
    aou_cpu_model_i.dup(1'b0);
    wt(3);
    `CHK("halt hold", run_led, 1'b0)
    aou_cpu_model_i.restart();
    wt(4);
    `CHK("rerun", run_led, 1'b1)
    // second reset in mid-run
    @(posedge clock);
    nrst <= 1'b0;
    wt(2);
    `CHK("rst run", run_led, 1'b0)
    `CHK("rst out", out_enable, 1'b0)
    @(posedge clock);
    nrst <= 1'b1;
    wt(4);
    `CHK("rst rerun", run_led, 1'b1)
    `CHK("rst unit", refresh_base, 8'd130)
    rd(12'h008);
    `CHK("rst ctrl", q, 32'h0)
    print_verdict();
  end
endmodule : tb
`default_nettype wire
